// ### hw/pwm_rate_regs.sv
// Function
// - Duty settings 0 and 255 hold the switch statically off or on.
// - A new duty value is used only once the running period has ended.
// - The two-bit rate code picks 100, 200, 325 or 400 Hz periods.
// - A rate change waits for the running period to finish.
// - Reserved bits of the rate and hardware registers read zero.
// - Bit 2 of the hardware register picks the higher thermal trip level.
// - Bits 1:0 of the hardware register set the regulator current limit.
// - With the lock set, soft reset keeps the threshold and limit fields.
// - Power-on loads the hardware register with 0x01.
// - The low scratch byte keeps its contents through soft reset.
// - Scratch bytes take writes only in normal mode and stay readable.
// - Internal logic never uses scratch bytes; they survive soft reset.
// - Scratch bytes hold data while powered and clear at power-up.
// - The high scratch byte is bits 15:8 and behaves like the low byte.
// - Duty 0 is off, 255 is on, anything else is on for value/255.
// - Lock blocks lockable writes until power-up, once select goes high.
//
// Decided for this implementation: the address-and-strobe port.
module pwm_rate_regs (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                soft_reset,
  input  wire logic                normal_mode,
  input  wire logic                chip_select_low_active,
  input  wire logic [6:0]          reg_addr,
  input  wire pwm_rate_pkg::byte_t reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output pwm_rate_pkg::byte_t      reg_rdata,
  output logic                     pwm_switch_on,
  output logic                     thermal_trip_level_select,
  output logic [1:0]               regulator_current_limit_step,
  output logic                     config_lock_active
);
  `include "pwm_rate_map.svh"

  pwm_rate_pkg::pwm_cfg_s cfg_req_reg;
  pwm_rate_pkg::pwm_cfg_s cfg_act;
  pwm_rate_pkg::hw3_cfg_s hw3_reg;
  pwm_rate_pkg::byte_t    scratch_word_low;
  pwm_rate_pkg::byte_t    scratch_word_high;
  logic                   lock_req_reg;
  logic                   cs_prev_reg;
  logic                   cs_rise;
  logic                   wr_duty;
  logic                   wr_rate;
  logic                   wr_hw3;
  logic                   wr_lock;
  logic                   wr_scr_lo;
  logic                   wr_scr_hi;

  assign wr_duty   = reg_wr && (reg_addr == `OFS_DUTY);
  assign wr_rate   = reg_wr && (reg_addr == `OFS_RATE);
  assign wr_hw3    = reg_wr && (reg_addr == `OFS_HW3);
  assign wr_lock   = reg_wr && (reg_addr == `OFS_CFG_LOCK);
  assign wr_scr_lo = reg_wr && (reg_addr == `OFS_SCR_LO);
  assign wr_scr_hi = reg_wr && (reg_addr == `OFS_SCR_HI);

  // Chip select is taken as already synchronous to clk
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg <= chip_select_low_active;
    end
  end
  assign cs_rise = chip_select_low_active && !cs_prev_reg;

  // Requested pwm config; soft reset clears it like power-on
  always_ff @(posedge clk) begin
    if (srst || soft_reset) begin
      cfg_req_reg.duty_fraction_value <= `DUTY_RST;
      cfg_req_reg.period_rate_code    <= `RATE_RST;
    end else begin
      if (wr_duty) begin
        cfg_req_reg.duty_fraction_value <= reg_wdata;
      end
      if (wr_rate) begin
        // Upper bits of the write are dropped
        cfg_req_reg.period_rate_code <=
          reg_wdata[`RATE_MSB:`RATE_LSB];
      end
    end
  end

  pwm_period_gen u_pwm (
    .clk       (clk),
    .srst      (srst),
    .cfg_req   (cfg_req_reg),
    .cfg_act   (cfg_act),
    .switch_on (pwm_switch_on)
  );

  // Lock request can be withdrawn until a select rise makes it permanent
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_req_reg <= 1'b0;
    end else if (wr_lock && !config_lock_active) begin
      lock_req_reg <= reg_wdata[`LOCK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      config_lock_active <= 1'b0;
    end else if (cs_rise && lock_req_reg) begin
      config_lock_active <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hw3_reg.thermal_trip_level_select    <= `HW3_THERM_RST;
      hw3_reg.regulator_current_limit_step <= `HW3_ILIM_RST;
    end else if (soft_reset && !config_lock_active) begin
      hw3_reg.thermal_trip_level_select    <= `HW3_THERM_RST;
      hw3_reg.regulator_current_limit_step <= `HW3_ILIM_RST;
    end else if (wr_hw3 && !soft_reset && !config_lock_active) begin
      hw3_reg.thermal_trip_level_select    <=
        reg_wdata[`THERM_BIT];
      hw3_reg.regulator_current_limit_step <=
        reg_wdata[`ILIM_MSB:`ILIM_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      thermal_trip_level_select    <= `HW3_THERM_RST;
      regulator_current_limit_step <= `HW3_ILIM_RST;
    end else begin
      thermal_trip_level_select    <= hw3_reg.thermal_trip_level_select;
      regulator_current_limit_step <= hw3_reg.regulator_current_limit_step;
    end
  end

  // Scratch bytes see no soft reset at all: nothing inside uses them
  scratch_byte u_scr_lo (
    .clk         (clk),
    .srst        (srst),
    .normal_mode (normal_mode),
    .wr_en       (wr_scr_lo),
    .wdata       (reg_wdata),
    .q           (scratch_word_low)
  );

  scratch_byte u_scr_hi (
    .clk         (clk),
    .srst        (srst),
    .normal_mode (normal_mode),
    .wr_en       (wr_scr_hi),
    .wdata       (reg_wdata),
    .q           (scratch_word_high)
  );

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `OFS_CFG_LOCK: reg_rdata <= {7'h00, lock_req_reg};
        `OFS_DUTY:     reg_rdata <= cfg_req_reg.duty_fraction_value;
        `OFS_RATE:     reg_rdata <= {6'h00,
                                     cfg_req_reg.period_rate_code};
        `OFS_HW3:      reg_rdata <= {5'h00, hw3_reg};
        `OFS_SCR_LO:   reg_rdata <= scratch_word_low;
        `OFS_SCR_HI:   reg_rdata <= scratch_word_high;
        default:       reg_rdata <= 8'h00;
      endcase
    end
  end

  property p_rate_reserved_zero;
    @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == `OFS_RATE) |=> (reg_rdata[7:2] == 6'h00);
  endproperty
  a_rate_reserved_zero : assert property (p_rate_reserved_zero)
    else $error("rate register reserved bits not zero");

  property p_hw3_reserved_zero;
    @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == `OFS_HW3) |=> (reg_rdata[7:3] == 5'h00);
  endproperty
  a_hw3_reserved_zero : assert property (p_hw3_reserved_zero)
    else $error("hardware register reserved bits not zero");

  property p_hw3_por;
    @(posedge clk) $fell(srst) |-> (hw3_reg == 3'h1);
  endproperty
  a_hw3_por : assert property (p_hw3_por)
    else $error("hardware register not 0x01 after power-on");

  property p_locked_soft_keeps;
    @(posedge clk) disable iff (srst)
      (soft_reset && config_lock_active) |=> $stable(hw3_reg);
  endproperty
  a_locked_soft_keeps : assert property (p_locked_soft_keeps)
    else $error("locked fields changed on soft reset");

  property p_unlocked_soft_default;
    @(posedge clk) disable iff (srst)
      (soft_reset && !config_lock_active) |=> (hw3_reg == 3'h1);
  endproperty
  a_unlocked_soft_default : assert property (p_unlocked_soft_default)
    else $error("unlocked fields not defaulted on soft reset");

  property p_locked_write_blocked;
    @(posedge clk) disable iff (srst)
      (wr_hw3 && config_lock_active) |=> $stable(hw3_reg);
  endproperty
  a_locked_write_blocked : assert property (p_locked_write_blocked)
    else $error("locked field took a write");

  property p_lock_on_cs_rise;
    @(posedge clk) disable iff (srst)
      (cs_rise && lock_req_reg) |=> config_lock_active;
  endproperty
  a_lock_on_cs_rise : assert property (p_lock_on_cs_rise)
    else $error("lock not active after select rise");

  property p_lock_waits_cs;
    @(posedge clk) disable iff (srst)
      (!config_lock_active && !cs_rise) |=> !config_lock_active;
  endproperty
  a_lock_waits_cs : assert property (p_lock_waits_cs)
    else $error("lock became active without select rise");

  property p_thermal_write;
    @(posedge clk) disable iff (srst)
      (wr_hw3 && !config_lock_active && !soft_reset) |=> ##1
        (thermal_trip_level_select == $past(reg_wdata[`THERM_BIT], 2));
  endproperty
  a_thermal_write : assert property (p_thermal_write)
    else $error("thermal select output did not follow write");

  property p_ilim_out;
    @(posedge clk) disable iff (srst)
      ##1 (regulator_current_limit_step ==
           $past(hw3_reg.regulator_current_limit_step));
  endproperty
  a_ilim_out : assert property (p_ilim_out)
    else $error("current limit output lags its register");

  property p_scratch_soft_keep;
    @(posedge clk) disable iff (srst)
      (soft_reset && !wr_scr_lo && !wr_scr_hi) |=>
        $stable(scratch_word_low) && $stable(scratch_word_high);
  endproperty
  a_scratch_soft_keep : assert property (p_scratch_soft_keep)
    else $error("scratch changed on soft reset");

  property p_scratch_readback;
    @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == `OFS_SCR_HI) |=>
        (reg_rdata == $past(scratch_word_high));
  endproperty
  a_scratch_readback : assert property (p_scratch_readback)
    else $error("high scratch byte read back wrong");

  property p_rdata_one_cycle;
    @(posedge clk) disable iff (srst)
      !reg_rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_one_cycle : assert property (p_rdata_one_cycle)
    else $error("read data stood outside its cycle");

  property p_lock_sticky;
    @(posedge clk) disable iff (srst)
      config_lock_active |=> config_lock_active;
  endproperty
  a_lock_sticky : assert property (p_lock_sticky)
    else $error("lock dropped without power-on");

  property p_lock_req_frozen;
    @(posedge clk) disable iff (srst)
      config_lock_active |=> $stable(lock_req_reg);
  endproperty
  a_lock_req_frozen : assert property (p_lock_req_frozen)
    else $error("lock request changed while locked");

  property p_hw3_readback;
    @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == `OFS_HW3) |=>
        (reg_rdata[2:0] == $past(hw3_reg));
  endproperty
  a_hw3_readback : assert property (p_hw3_readback)
    else $error("hardware register read back wrong");

  property p_scratch_lo_readback;
    @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == `OFS_SCR_LO) |=>
        (reg_rdata == $past(scratch_word_low));
  endproperty
  a_scratch_lo_readback : assert property (p_scratch_lo_readback)
    else $error("low scratch byte read back wrong");

  property p_scratch_por;
    @(posedge clk) $fell(srst) |->
      (scratch_word_low == 8'h00) && (scratch_word_high == 8'h00);
  endproperty
  a_scratch_por : assert property (p_scratch_por)
    else $error("scratch bytes not clear after power-on");

  property p_rate_request;
    @(posedge clk) disable iff (srst)
      (wr_rate && !soft_reset) |=>
        (cfg_req_reg.period_rate_code == $past(reg_wdata[1:0]));
  endproperty
  a_rate_request : assert property (p_rate_request)
    else $error("rate request did not take the write");

  c_lock_taken   : cover property (@(posedge clk) disable iff (srst)
                                   cs_rise && lock_req_reg);
  c_locked_soft  : cover property (@(posedge clk) disable iff (srst)
                                   soft_reset && config_lock_active);
  c_scr_stop_rd  : cover property (@(posedge clk) disable iff (srst)
                                   reg_rd && !normal_mode &&
                                   reg_addr == `OFS_SCR_LO);
  c_rate_change  : cover property (@(posedge clk) disable iff (srst)
                                   wr_rate && reg_wdata[1:0] == 2'h2);
endmodule

// ### hw/pwm_rate_map.svh
`ifndef PWM_RATE_MAP_SVH
`define PWM_RATE_MAP_SVH

// Register offsets on the 7-bit register port
`define OFS_CFG_LOCK   7'h0f
`define OFS_DUTY       7'h18
`define OFS_RATE       7'h1c
`define OFS_HW3        7'h1d
`define OFS_SCR_LO     7'h1e
`define OFS_SCR_HI     7'h1f

// Field positions
`define LOCK_BIT       0
`define RATE_MSB       1
`define RATE_LSB       0
`define THERM_BIT      2
`define ILIM_MSB       1
`define ILIM_LSB       0

// Reset values
`define DUTY_RST       8'h00
`define RATE_RST       2'h0
`define HW3_THERM_RST  1'b0
`define HW3_ILIM_RST   2'h1
`define SCR_RST        8'h00

// Period rate codes
`define RATE_CODE_100  2'h0
`define RATE_CODE_200  2'h1
`define RATE_CODE_325  2'h2
`define RATE_CODE_400  2'h3

// Timing: rates in Hz, one period is split into 255 duty slots
`define CLK_HZ         40000000
`define RATE_100_HZ    100
`define RATE_200_HZ    200
`define RATE_325_HZ    325
`define RATE_400_HZ    400
`define DUTY_SLOTS     255
`define LAST_SLOT      8'hfe
`define SLOT_CYC(hz)   (`CLK_HZ / ((hz) * `DUTY_SLOTS))

`endif

// ### hw/pwm_rate_pkg.sv
package pwm_rate_pkg;
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic [1:0] period_rate_code;
    logic [7:0] duty_fraction_value;
  } pwm_cfg_s;

  typedef struct packed {
    logic       thermal_trip_level_select;
    logic [1:0] regulator_current_limit_step;
  } hw3_cfg_s;
endpackage

// ### hw/scratch_byte.sv
module scratch_byte (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 normal_mode,
  input  wire logic                 wr_en,
  input  wire pwm_rate_pkg::byte_t  wdata,
  output pwm_rate_pkg::byte_t       q
);
  `include "pwm_rate_map.svh"

  // Only power-on clears the byte; soft reset and mode changes never touch it
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= `SCR_RST;
    end else if (wr_en && normal_mode) begin
      q <= wdata;
    end
  end

  property p_no_write_off_normal;
    @(posedge clk) disable iff (srst)
      (wr_en && !normal_mode) |=> $stable(q);
  endproperty
  a_no_write_off_normal : assert property (p_no_write_off_normal)
    else $error("scratch byte changed outside normal mode");

  property p_write_in_normal;
    @(posedge clk) disable iff (srst)
      (wr_en && normal_mode) |=> (q == $past(wdata));
  endproperty
  a_write_in_normal : assert property (p_write_in_normal)
    else $error("scratch byte did not take a normal-mode write");
endmodule

// ### hw/pwm_period_gen.sv
module pwm_period_gen (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire pwm_rate_pkg::pwm_cfg_s cfg_req,
  output pwm_rate_pkg::pwm_cfg_s      cfg_act,
  output logic                        switch_on
);
  `include "pwm_rate_map.svh"

  localparam logic [10:0] SLOT_100 = 11'(`SLOT_CYC(`RATE_100_HZ));
  localparam logic [10:0] SLOT_200 = 11'(`SLOT_CYC(`RATE_200_HZ));
  localparam logic [10:0] SLOT_325 = 11'(`SLOT_CYC(`RATE_325_HZ));
  localparam logic [10:0] SLOT_400 = 11'(`SLOT_CYC(`RATE_400_HZ));

  logic [10:0] slot_len;
  logic [10:0] presc_reg;
  logic [7:0]  slot_reg;
  logic        slot_tick;
  logic        period_wrap;

  always_comb begin
    case (cfg_act.period_rate_code)
      `RATE_CODE_100: slot_len = SLOT_100;
      `RATE_CODE_200: slot_len = SLOT_200;
      `RATE_CODE_325: slot_len = SLOT_325;
      default:        slot_len = SLOT_400;
    endcase
  end

  assign slot_tick   = (presc_reg == slot_len - 11'h1);
  assign period_wrap = slot_tick && (slot_reg == `LAST_SLOT);

  always_ff @(posedge clk) begin
    if (srst || slot_tick) begin
      presc_reg <= 11'h0;
    end else begin
      presc_reg <= presc_reg + 11'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || period_wrap) begin
      slot_reg <= 8'h0;
    end else if (slot_tick) begin
      slot_reg <= slot_reg + 8'h1;
    end
  end

  // New duty and rate are taken only at the end of a whole period
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_act <= '0;
    end else if (period_wrap) begin
      cfg_act <= cfg_req;
    end
  end

  // Slots run 0..254, so duty 0 never turns on and 255 never turns off
  always_ff @(posedge clk) begin
    if (srst) begin
      switch_on <= 1'b0;
    end else begin
      switch_on <= (slot_reg < cfg_act.duty_fraction_value);
    end
  end

  property p_hold_mid_period;
    @(posedge clk) disable iff (srst)
      !period_wrap |=> $stable(cfg_act);
  endproperty
  a_hold_mid_period : assert property (p_hold_mid_period)
    else $error("active pwm config changed inside a period");

  property p_load_at_wrap;
    @(posedge clk) disable iff (srst)
      period_wrap |=> (cfg_act == $past(cfg_req));
  endproperty
  a_load_at_wrap : assert property (p_load_at_wrap)
    else $error("requested pwm config not taken at period end");

  property p_static_off;
    @(posedge clk) disable iff (srst)
      (cfg_act.duty_fraction_value == 8'h00) [*2] |-> !switch_on;
  endproperty
  a_static_off : assert property (p_static_off)
    else $error("switch on with zero duty");

  property p_static_on;
    @(posedge clk) disable iff (srst)
      (cfg_act.duty_fraction_value == 8'hff) [*2] |-> switch_on;
  endproperty
  a_static_on : assert property (p_static_on)
    else $error("switch off with full duty");

  property p_slot_len;
    @(posedge clk) disable iff (srst)
      (slot_tick && cfg_act.period_rate_code == `RATE_CODE_400)
        |-> (presc_reg == 11'h187);
  endproperty
  a_slot_len : assert property (p_slot_len)
    else $error("slot length wrong for fastest rate");

  c_wrap : cover property (@(posedge clk) disable iff (srst) period_wrap);
endmodule

// ### bench/host_port_model.sv
module host_port_model (
  input  wire logic                clk,
  input  wire pwm_rate_pkg::byte_t reg_rdata,
  output logic [6:0]               reg_addr,
  output pwm_rate_pkg::byte_t      reg_wdata,
  output logic                     reg_wr,
  output logic                     reg_rd,
  output logic                     chip_select_low_active
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chip_select_low_active = 1'b1;
  end

  // Released address and data lines show the inverse, so a stale value
  // can never pass for a fresh one
  task automatic write_reg(input logic [6:0] addr,
                           input pwm_rate_pkg::byte_t data);
    @(posedge clk);
    chip_select_low_active <= 1'b0;
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask

  task automatic read_reg(input logic [6:0] addr,
                          output pwm_rate_pkg::byte_t data);
    @(posedge clk);
    chip_select_low_active <= 1'b0;
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    @(posedge clk);
    data = reg_rdata;
  endtask

  // Select stays low across accesses until the frame is closed here
  task automatic end_frame();
    @(posedge clk);
    chip_select_low_active <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Duty goes in before the period rate; both take effect at the next period end
  task automatic setup_pwm(input pwm_rate_pkg::byte_t duty,
                           input logic [1:0] rate);
    write_reg(7'h18, duty);
    write_reg(7'h1c, {6'h00, rate});
  endtask
endmodule

// ### bench/pwm_rate_regs_bench.sv
module pwm_rate_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CYCLE_LIMIT = 20000;

  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic                soft_reset = 1'b0;
  logic                normal_mode = 1'b1;
  logic                chip_select_low_active;
  logic [6:0]          reg_addr;
  pwm_rate_pkg::byte_t reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  pwm_rate_pkg::byte_t reg_rdata;
  logic                pwm_switch_on;
  logic                thermal_trip_level_select;
  logic [1:0]          regulator_current_limit_step;
  logic                config_lock_active;
  int                  errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  int                  on_seen;
  pwm_rate_pkg::byte_t rd;

  always #12.5 clk = ~clk;

  pwm_rate_regs DUT (
    .clk                          (clk),
    .srst                         (srst),
    .soft_reset                   (soft_reset),
    .normal_mode                  (normal_mode),
    .chip_select_low_active       (chip_select_low_active),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_rdata                    (reg_rdata),
    .pwm_switch_on                (pwm_switch_on),
    .thermal_trip_level_select    (thermal_trip_level_select),
    .regulator_current_limit_step (regulator_current_limit_step),
    .config_lock_active           (config_lock_active)
  );

  host_port_model host (
    .clk                    (clk),
    .reg_rdata              (reg_rdata),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .chip_select_low_active (chip_select_low_active)
  );

  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input pwm_rate_pkg::byte_t seen,
                       input pwm_rate_pkg::byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_reg(input logic [6:0] addr,
                            input pwm_rate_pkg::byte_t exp);
    host.read_reg(addr, rd);
    check(rd, exp);
  endtask

  task automatic pulse_soft_reset();
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    check({7'h00, config_lock_active}, 8'h00);
    check({5'h00, thermal_trip_level_select,
           regulator_current_limit_step}, 8'h01);
    expect_reg(7'h1c, 8'h00);
    expect_reg(7'h1d, 8'h01);
    expect_reg(7'h1e, 8'h00);
    expect_reg(7'h1f, 8'h00);
    // Every threshold and limit code, reserved bits set alongside
    for (int i = 0; i < 8; i++) begin
      host.write_reg(7'h1d, 8'hf8 | 8'(i));
      expect_reg(7'h1d, 8'(i));
      check({5'h00, thermal_trip_level_select,
             regulator_current_limit_step}, 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      host.write_reg(7'h1c, 8'hfc | 8'(i));
      expect_reg(7'h1c, 8'(i));
    end
    host.write_reg(7'h40, 8'hff);
    expect_reg(7'h40, 8'h00);
    // Full duty at the fastest rate must wait out the running period
    host.setup_pwm(8'hff, 2'h3);
    expect_reg(7'h18, 8'hff);
    on_seen = 0;
    repeat (2000) begin
      @(posedge clk);
      if (pwm_switch_on !== 1'b0) on_seen++;
    end
    check((on_seen == 0) ? 8'h00 : 8'h01, 8'h00);
    host.write_reg(7'h1e, 8'h5a);
    host.write_reg(7'h1f, 8'ha5);
    @(posedge clk);
    normal_mode <= 1'b0;
    host.write_reg(7'h1e, 8'h00);
    host.write_reg(7'h1f, 8'hff);
    expect_reg(7'h1e, 8'h5a);
    expect_reg(7'h1f, 8'ha5);
    @(posedge clk);
    normal_mode <= 1'b1;
    pulse_soft_reset();
    expect_reg(7'h1e, 8'h5a);
    expect_reg(7'h1f, 8'ha5);
    expect_reg(7'h1d, 8'h01);
    expect_reg(7'h1c, 8'h00);
    expect_reg(7'h18, 8'h00);
    // Lock waits for the select to rise, then holds until power-up
    host.write_reg(7'h1d, 8'h06);
    host.write_reg(7'h0f, 8'h01);
    repeat (3) @(posedge clk);
    check({7'h00, config_lock_active}, 8'h00);
    host.end_frame();
    check({7'h00, config_lock_active}, 8'h01);
    host.write_reg(7'h1d, 8'h01);
    expect_reg(7'h1d, 8'h06);
    check({5'h00, thermal_trip_level_select,
           regulator_current_limit_step}, 8'h06);
    host.write_reg(7'h0f, 8'h00);
    host.end_frame();
    check({7'h00, config_lock_active}, 8'h01);
    expect_reg(7'h0f, 8'h01);
    pulse_soft_reset();
    expect_reg(7'h1d, 8'h06);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check({7'h00, config_lock_active}, 8'h00);
    expect_reg(7'h1d, 8'h01);
    expect_reg(7'h1e, 8'h00);
    expect_reg(7'h1f, 8'h00);
    give_verdict();
  end
endmodule
